//--- hdl/psr_ctrl.sv
/*
  Host-side controller for an 8192 x 8 edge-triggered pseudo-static RAM.
  Drives cycle strobe, output gate, write strobe, refresh request, address
  and a three-signal data bus; runs read, write, dummy row and extended
  self-refresh cycles, and schedules periodic refresh itself.
  Assumes: requests come from logic on ref_clk; ram_dq_in is an external pin.
*/
// Notes on behaviour
// R1: Memory holds 8192 bytes, 13-bit address, 8 two-way data lines.
// R2: Read data sampled no earlier than 120 ns after strobe falls.
// R3: Strobe falling edges spaced at least 175 ns apart.
// R4: At least 100 ns from output gate low to next strobe fall.
// R5: Output gate high at least 15 ns before next strobe fall.
// R6: Device floats data within 40 ns after output gate rises.
// R7: Write strobe high at least 15 ns before next strobe fall.
// R8: Output gate stays high throughout a write cycle.
// R9: Write strobe stays high throughout a read cycle.
// R10: Strobe with gate and write strobe high is a dummy row cycle.
// R11: After dummy row cycle, strobe stays high at least 90 ns.
// R12: After dummy row cycle, 100 ns before refresh request falls.
// R13: Refresh overlapping an access stretches strobe spacing to 350 ns.
// R14: Refresh request pulsed at intervals of at most 31000 ns.
// R15: Refresh request low 5000 ns or more is an extended cycle.
// R16: After extended pulse, refresh request high at least 175 ns.
// R17: After extended pulse, 170 ns before next strobe fall.
// R18: Device latches the address at strobe fall for the cycle.
// R19: Refresh request fall queues a refresh after any current access.
// R20: At least 256 refresh pulses every 4 ms.
// R21: Power-up: refresh request low, others high, for 100 us.
// R22: Device drives data only while output gate is low in a read.
`timescale 1ns/1ps
`include "psr_defs.svh"

module psr_ctrl (
  input  wire logic              ref_clk,
  input  wire logic              arst_n,
  input  wire logic              req_valid,
  input  wire psr_pkg::psr_op_t  req_op,
  input  wire psr_pkg::psr_addr_t req_addr,
  input  wire psr_pkg::psr_data_t req_wdata,
  output logic                   req_ready,
  output logic                   rsp_valid,
  output psr_pkg::psr_data_t     rsp_rdata,
  output logic                   ram_ce_n,
  output logic                   ram_oe_n,
  output logic                   ram_we_n,
  output logic                   refresh_request_n,
  output psr_pkg::psr_addr_t     ram_addr,
  input  wire psr_pkg::psr_data_t ram_dq_in,
  output psr_pkg::psr_data_t     ram_dq_out,
  output logic                   ram_dq_oe
);

  typedef enum logic [3:0] {
    PSR_INIT,
    PSR_IDLE,
    PSR_RD,
    PSR_WR,
    PSR_DUMMY,
    PSR_REF,
    PSR_EXT,
    PSR_GAP
  } psr_state_t;

  typedef struct packed {
    psr_state_t          state;
    psr_pkg::psr_op_t    op;
    logic [16:0]         step;
    logic [16:0]         gap;
    logic [16:0]         ref_age;
    logic                ref_due;
    logic                ce_n;
    logic                oe_n;
    logic                we_n;
    logic                ref_n;
    psr_pkg::psr_addr_t  addr;
    psr_pkg::psr_data_t  dq_out;
    logic                dq_oe;
    logic                ready;
    logic                rsp_valid;
    psr_pkg::psr_data_t  rdata;
    logic [2:0][7:0]     sync;
  } psr_ctrl_st_t;

  psr_ctrl_st_t st_r;
  psr_ctrl_st_t st_nxt;
  logic         tmr_load;
  logic [16:0]  tmr_count;
  logic         tmr_done;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [16:0] cyc(input int n);
    cyc = 17'(n);
  endfunction

  // Strobe spacing after dummy row and extended cycles, held to the longest limit
  function automatic logic [16:0] gap_after(input psr_pkg::psr_op_t op);
    case (op)
      psr_pkg::PSR_OP_DUMMY: gap_after = cyc(`PSR_FMCREF_CYC);
      psr_pkg::PSR_OP_EXT:   gap_after = cyc(`PSR_EXTH_CYC);
      default:               gap_after = cyc(`PSR_OEH_CYC);
    endcase
  endfunction

  psr_timer u_timer (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .load    (tmr_load),
    .count   (tmr_count),
    .done    (tmr_done)
  );

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt    = st_r;
    tmr_load  = 1'b0;
    tmr_count = 17'h0_0000;
    st_nxt.rsp_valid = 1'b0;
    // Three-stage pin sampler; only the last stage is used
    st_nxt.sync[0] = ram_dq_in;
    st_nxt.sync[1] = st_r.sync[0];
    st_nxt.sync[2] = st_r.sync[1];
    st_nxt.step = st_r.step + 17'h0_0001;
    // Burst-rate bound is the tighter one; it also keeps every gap short
    if (st_r.ref_age != 17'h1_ffff) begin
      st_nxt.ref_age = st_r.ref_age + 17'h0_0001;
    end
    if (st_r.ref_age >= cyc(`PSR_REFWIN_CYC - `PSR_REFCYC_CYC - `PSR_EXTP_CYC / 50)) begin
      st_nxt.ref_due = 1'b1; // see R14 see R20
    end
    case (st_r.state)
      PSR_INIT: begin
        st_nxt.ref_n = 1'b0; // see R21
        st_nxt.ce_n  = 1'b1;
        st_nxt.oe_n  = 1'b1;
        st_nxt.we_n  = 1'b1;
        if (st_r.step >= cyc(`PSR_INIT_CYC)) begin
          st_nxt.ref_n   = 1'b1;
          st_nxt.state   = PSR_GAP;
          st_nxt.gap     = cyc(`PSR_EXTCE_CYC); // see R17
          st_nxt.step    = 17'h0_0000;
          st_nxt.ref_age = 17'h0_0000;
        end
      end
      PSR_IDLE: begin
        st_nxt.ready = 1'b0;
        if (st_r.ref_due) begin
          // Refresh first: starts idle, so no overlap stretch is needed
          st_nxt.state   = PSR_REF;
          st_nxt.ref_n   = 1'b0; // see R19
          st_nxt.ref_due = 1'b0;
          st_nxt.ref_age = 17'h0_0000;
          st_nxt.step    = 17'h0_0000;
        end else if (req_valid && st_r.ready) begin
          // Address set with the strobe fall, held for the whole cycle
          st_nxt.op    = req_op;
          st_nxt.addr  = req_addr; // see R1 see R18
          st_nxt.step  = 17'h0_0000;
          if (req_op == psr_pkg::PSR_OP_EXT) begin
            st_nxt.state = PSR_EXT;
            st_nxt.ref_n = 1'b0; // see R15
          end else begin
            st_nxt.ce_n = 1'b0;
            case (req_op)
              psr_pkg::PSR_OP_READ: begin
                st_nxt.state = PSR_RD;
                st_nxt.oe_n  = 1'b0; // see R9
              end
              psr_pkg::PSR_OP_WRITE: begin
                st_nxt.state  = PSR_WR;
                st_nxt.we_n   = 1'b0; // see R8
                st_nxt.dq_out = req_wdata;
                st_nxt.dq_oe  = 1'b1;
              end
              default: begin
                st_nxt.state = PSR_DUMMY; // see R10
              end
            endcase
          end
        end else begin
          // Offer no slot that a pending refresh would take instead
          st_nxt.ready = !st_nxt.ref_due;
        end
      end
      PSR_RD: begin
        if (st_r.step == cyc(`PSR_CEP_CYC - 1)) begin
          st_nxt.ce_n = 1'b1;
        end
        // Pin sampler adds two cycles of lag; one more keeps the pin
        // sample off the edge at which the access time runs out
        if (st_r.step == cyc(`PSR_ACC_CYC + 3)) begin
          st_nxt.rdata     = st_r.sync[2]; // see R2
          st_nxt.rsp_valid = 1'b1;
          st_nxt.oe_n      = 1'b1; // see R22
        end
        if (st_r.step >= cyc(`PSR_ACC_CYC + 3) && st_r.step >= cyc(`PSR_OECE_CYC)) begin
          st_nxt.state = PSR_GAP; // see R4
          st_nxt.oe_n  = 1'b1;
          // Device may still drive for the float time; wait it out
          st_nxt.gap   = cyc(`PSR_FLOAT_CYC); // see R5 see R6
          st_nxt.step  = 17'h0_0000;
        end
      end
      PSR_WR: begin
        if (st_r.step == cyc(`PSR_CEP_CYC - 1)) begin
          st_nxt.ce_n = 1'b1;
        end
        if (st_r.step == cyc(`PSR_WEP_CYC - 1)) begin
          st_nxt.we_n = 1'b1;
        end
        if (st_r.step >= cyc(`PSR_WECE_CYC - `PSR_WEH_CYC)) begin
          st_nxt.state = PSR_GAP;
          st_nxt.we_n  = 1'b1;
          st_nxt.dq_oe = 1'b0;
          st_nxt.gap   = cyc(`PSR_WEH_CYC); // see R7
          st_nxt.step  = 17'h0_0000;
        end
      end
      PSR_DUMMY: begin
        if (st_r.step >= cyc(`PSR_CEP_CYC - 1)) begin
          st_nxt.ce_n  = 1'b1;
          st_nxt.state = PSR_GAP;
          st_nxt.gap   = gap_after(st_r.op); // see R11 see R12
          st_nxt.step  = 17'h0_0000;
        end
      end
      PSR_REF: begin
        if (st_r.step >= cyc(`PSR_REFP_CYC - 1)) begin
          st_nxt.ref_n = 1'b1;
          st_nxt.state = PSR_GAP;
          st_nxt.gap   = cyc(`PSR_REFCE_CYC - `PSR_REFP_CYC); // see R13
          st_nxt.step  = 17'h0_0000;
        end
      end
      PSR_EXT: begin
        st_nxt.ref_age = 17'h0_0000;
        if (st_r.step >= cyc(`PSR_EXTP_CYC - 1) &&
            !(req_valid && req_op == psr_pkg::PSR_OP_EXT)) begin
          st_nxt.ref_n     = 1'b1;
          st_nxt.rsp_valid = 1'b1;
          st_nxt.state     = PSR_GAP;
          st_nxt.gap       = gap_after(st_r.op); // see R16 see R17
          st_nxt.step      = 17'h0_0000;
        end
      end
      PSR_GAP: begin
        if (st_r.step >= st_r.gap) begin
          st_nxt.state = PSR_IDLE;
          st_nxt.ready = 1'b0;
          // Spacing timer runs on from the strobe fall; a reload would cut it
        end
      end
      default: begin
        st_nxt.state = PSR_IDLE;
      end
    endcase
    // Strobe-to-strobe spacing is also enforced from the last fall
    if (st_nxt.ce_n == 1'b0 && st_r.ce_n == 1'b1 && !tmr_done) begin
      st_nxt = st_r; // Guard only: ready already waits for the spacing timer
    end
    if (st_nxt.ce_n == 1'b0 && st_r.ce_n == 1'b1) begin
      tmr_load  = 1'b1;
      tmr_count = cyc(`PSR_CYC_CYC - 1); // see R3
    end
    if (st_r.state == PSR_IDLE && !tmr_done) begin
      st_nxt.ready = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r       <= '0;
      st_r.state <= PSR_INIT;
      st_r.ce_n  <= 1'b1;
      st_r.oe_n  <= 1'b1;
      st_r.we_n  <= 1'b1;
      st_r.ref_n <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------

  assign req_ready         = st_r.ready;
  assign rsp_valid         = st_r.rsp_valid;
  assign rsp_rdata         = st_r.rdata;
  assign ram_ce_n          = st_r.ce_n;
  assign ram_oe_n          = st_r.oe_n;
  assign ram_we_n          = st_r.we_n;
  assign refresh_request_n = st_r.ref_n;
  assign ram_addr          = st_r.addr;
  assign ram_dq_out        = st_r.dq_out;
  assign ram_dq_oe         = st_r.dq_oe;

endmodule

//--- hdl/psr_defs.svh
/*
  Timing constants for the pseudo-static RAM cycle controller.
  Assumes a 100 MHz ref_clk; all times are printed in ns and converted here.
*/
`ifndef PSR_DEFS_SVH
`define PSR_DEFS_SVH

`define PSR_CLK_NS            10
`define PSR_CYC_NS            175
`define PSR_ACC_NS            120
`define PSR_OE_TO_CE_NS       100
`define PSR_OE_HIGH_NS        15
`define PSR_FLOAT_NS          40
`define PSR_WE_HIGH_NS        15
`define PSR_WE_PULSE_NS       20
`define PSR_WE_TO_CE_NS       120
`define PSR_CE_PULSE_NS       25
`define PSR_FMC_HIGH_NS       90
`define PSR_FMC_TO_REF_NS     100
`define PSR_REF_CYC_NS        350
`define PSR_REF_PULSE_NS      20
`define PSR_REF_LOW_TO_CE_NS  175
`define PSR_REF_HIGH_CE_NS    15
`define PSR_REF_INT_NS        31000
`define PSR_EXT_PULSE_NS      5000
`define PSR_EXT_HIGH_NS       175
`define PSR_EXT_TO_CE_NS      170
`define PSR_INIT_NS           100000
`define PSR_REF_WIN_NS        4000000
`define PSR_REF_WIN_CNT       256

// Least times round up, longest times round down
`define PSR_CYC_MIN(ns)  (((ns) + `PSR_CLK_NS - 1) / `PSR_CLK_NS)
`define PSR_CYC_MAX(ns)  ((ns) / `PSR_CLK_NS)

`define PSR_ACC_CYC       `PSR_CYC_MAX(`PSR_ACC_NS)
`define PSR_CYC_CYC       `PSR_CYC_MIN(`PSR_CYC_NS)
`define PSR_OECE_CYC      `PSR_CYC_MIN(`PSR_OE_TO_CE_NS)
`define PSR_OEH_CYC       `PSR_CYC_MIN(`PSR_OE_HIGH_NS)
`define PSR_FLOAT_CYC     `PSR_CYC_MIN(`PSR_FLOAT_NS)
`define PSR_WEH_CYC       `PSR_CYC_MIN(`PSR_WE_HIGH_NS)
`define PSR_WEP_CYC       `PSR_CYC_MIN(`PSR_WE_PULSE_NS)
`define PSR_WECE_CYC      `PSR_CYC_MIN(`PSR_WE_TO_CE_NS)
`define PSR_CEP_CYC       `PSR_CYC_MIN(`PSR_CE_PULSE_NS)
`define PSR_FMCH_CYC      `PSR_CYC_MIN(`PSR_FMC_HIGH_NS)
`define PSR_FMCREF_CYC    `PSR_CYC_MIN(`PSR_FMC_TO_REF_NS)
`define PSR_REFCYC_CYC    `PSR_CYC_MIN(`PSR_REF_CYC_NS)
`define PSR_REFP_CYC      `PSR_CYC_MIN(`PSR_REF_PULSE_NS)
`define PSR_REFCE_CYC     `PSR_CYC_MIN(`PSR_REF_LOW_TO_CE_NS)
`define PSR_REFHCE_CYC    `PSR_CYC_MIN(`PSR_REF_HIGH_CE_NS)
`define PSR_REFINT_CYC    `PSR_CYC_MAX(`PSR_REF_INT_NS)
`define PSR_EXTP_CYC      `PSR_CYC_MIN(`PSR_EXT_PULSE_NS)
`define PSR_EXTH_CYC      `PSR_CYC_MIN(`PSR_EXT_HIGH_NS)
`define PSR_EXTCE_CYC     `PSR_CYC_MIN(`PSR_EXT_TO_CE_NS)
`define PSR_INIT_CYC      `PSR_CYC_MIN(`PSR_INIT_NS)
`define PSR_REFWIN_CYC    `PSR_CYC_MAX(`PSR_REF_WIN_NS / `PSR_REF_WIN_CNT)

`endif

//--- hdl/psr_pkg.sv
/*
  Types for the pseudo-static RAM cycle controller.
  Assumes psr_defs.svh supplies the timing constants.
*/
package psr_pkg;

  typedef enum logic [1:0] {
    PSR_OP_READ,
    PSR_OP_WRITE,
    PSR_OP_DUMMY,
    PSR_OP_EXT
  } psr_op_t;

  typedef logic [12:0] psr_addr_t;
  typedef logic [7:0]  psr_data_t;

endpackage

//--- hdl/psr_timer.sv
/*
  Down-counting interval timer; done is high once the loaded count has run out.
  Assumes a single ref_clk domain and an active-low asynchronous reset.
*/
`timescale 1ns/1ps

module psr_timer (
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  input  wire logic        load,
  input  wire logic [16:0] count,
  output logic             done
);

  typedef struct packed {
    logic [16:0] cnt;
  } psr_tmr_st_t;

  psr_tmr_st_t st_r;
  psr_tmr_st_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (load) begin
      st_nxt.cnt = count;
    end else if (st_r.cnt != 17'h0_0000) begin
      st_nxt.cnt = st_r.cnt - 17'h0_0001;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign done = (st_r.cnt == 17'h0_0000);

endmodule

//--- verif/psr_ctrl_chk.sv
/* Pin timing checker for the pseudo-static RAM controller.
   Assumes it is bound to psr_ctrl and sees one ref_clk domain. */
`timescale 1ns/1ps
module psr_ctrl_chk (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic req_ready,
  input wire logic ram_ce_n,
  input wire logic ram_oe_n,
  input wire logic ram_we_n,
  input wire logic refresh_request_n,
  input wire logic ram_dq_oe
);
  // ----------------------------------------
  // Edge ages
  // ----------------------------------------
  // Ages: ce fall, oe fall, oe rise, we rise, ce rise, ref rise, ref fall
  logic [6:0]  ev;
  logic [15:0] age_r [7];
  logic [15:0] low_r;
  logic [15:0] high_r;
  logic [15:0] boot_r;
  logic        ce_q, oe_q, we_q, rf_q, fmc_r, ext_r;

  assign ev = {rf_q & ~refresh_request_n, ~rf_q & refresh_request_n, ~ce_q & ram_ce_n,
               ~we_q & ram_we_n, ~oe_q & ram_oe_n, oe_q & ~ram_oe_n, ce_q & ~ram_ce_n};

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 7; i++) begin
        age_r[i] <= 16'hffff;
      end
      {ce_q, oe_q, we_q, rf_q, fmc_r, ext_r} <= 6'h38;
      low_r <= 16'h0;
      high_r <= 16'h0;
      boot_r <= 16'h0;
    end else begin
      for (int i = 0; i < 7; i++) begin
        age_r[i] <= ev[i] ? 16'h1 : age_r[i] + {15'h0, age_r[i] != 16'hffff};
      end
      {ce_q, oe_q, we_q, rf_q} <= {ram_ce_n, ram_oe_n, ram_we_n, refresh_request_n};
      if (ev[0]) begin
        fmc_r <= ram_oe_n & ram_we_n;
      end
      // Long low pulse marks an extended cycle
      if (ev[5]) begin
        ext_r <= (low_r >= 16'h01f4);
      end else if (ev[6]) begin
        ext_r <= 1'b0;
      end
      low_r <= refresh_request_n ? 16'h0 : low_r + 16'h1;
      high_r <= refresh_request_n ? high_r + 16'h1 : 16'h0;
      boot_r <= boot_r + {15'h0, boot_r != 16'hffff};
    end
  end

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  a_strobe_spacing: assert property ($fell(ram_ce_n) |-> age_r[0] >= 16'h0012)
    else $error("strobe falls closer than 18 cycles");
  a_gate_to_strobe: assert property ($fell(ram_ce_n) |-> age_r[1] >= 16'h000a)
    else $error("gate low too close to next strobe");
  a_gate_high_time: assert property ($fell(ram_ce_n) |-> age_r[2] >= 16'h0002)
    else $error("gate high too short before strobe");
  a_write_high_time: assert property ($fell(ram_ce_n) |-> age_r[3] >= 16'h0002)
    else $error("write strobe high too short before strobe");
  a_write_no_gate: assert property ((!ram_we_n || ram_dq_oe) |-> ram_oe_n)
    else $error("gate active in write");
  a_read_no_write: assert property (!ram_oe_n |-> ram_we_n && !ram_dq_oe)
    else $error("write strobe or drive active in read");
  a_dummy_recovery: assert property ($fell(ram_ce_n) && fmc_r |-> age_r[4] >= 16'h0009)
    else $error("strobe high too short after dummy cycle");
  a_dummy_to_refresh: assert property (
    $fell(refresh_request_n) && fmc_r |-> age_r[4] >= 16'h000a)
    else $error("refresh too soon after dummy cycle");
  a_refresh_due: assert property (high_r <= 16'h061a)
    else $error("refresh interval too long");
  a_ext_to_strobe: assert property ($fell(ram_ce_n) && ext_r |-> age_r[5] >= 16'h0011)
    else $error("strobe too soon after extended pulse");
  a_power_up_hold: assert property (
    boot_r < 16'h270f |-> !refresh_request_n && ram_ce_n && !req_ready)
    else $error("init phase broken");
endmodule

bind psr_ctrl psr_ctrl_chk u_psr_ctrl_chk (
  .ref_clk(ref_clk),
  .arst_n(arst_n),
  .req_ready(req_ready),
  .ram_ce_n(ram_ce_n),
  .ram_oe_n(ram_oe_n),
  .ram_we_n(ram_we_n),
  .refresh_request_n(refresh_request_n),
  .ram_dq_oe(ram_dq_oe)
);

//--- verif/psr_ram_model.sv
/* Behavioural model of the 8192 x 8 pseudo-static RAM.
   Assumes controller pins; resolves the shared data wire for both sides. */
`timescale 1ns/1ps
module psr_ram_model #(
  parameter int ACC_NS = 120
) (
  input  wire logic               ram_ce_n,
  input  wire logic               ram_oe_n,
  input  wire logic               ram_we_n,
  input  wire logic               refresh_request_n,
  input  wire psr_pkg::psr_addr_t ram_addr,
  input  wire psr_pkg::psr_data_t ram_dq_out,
  input  wire logic               ram_dq_oe,
  output psr_pkg::psr_data_t      ram_dq_in,
  output int                      ext_count
);
  // ----------------------------------------
  // Array and pins
  // ----------------------------------------
  psr_pkg::psr_data_t mem [8192];
  psr_pkg::psr_addr_t addr_l;
  psr_pkg::psr_data_t last_d = 8'h5a;
  logic               rd_ok = 1'b0;
  logic               drive;
  time                rf_t = 0;

  initial ext_count = 0;

  // Slow device: data only at the latest allowed moment
  always @(negedge ram_ce_n) begin
    rd_ok = 1'b0;
    #1;
    addr_l = ram_addr;
    #(ACC_NS - 1);
    rd_ok = 1'b1;
  end

  // Later than the address latch, so the write lands at the latched row
  always @(negedge ram_we_n) begin
    #2;
    mem[addr_l] = ram_dq_out;
  end

  assign drive = !ram_oe_n && ram_we_n && rd_ok;

  always @(negedge drive) begin
    if (!$isunknown(addr_l)) begin
      last_d = mem[addr_l];
    end
  end

  // Released wire shows the inverse so a stale sample cannot pass
  assign ram_dq_in = ram_dq_oe ? ram_dq_out : (drive ? mem[addr_l] : ~last_d);

  always @(negedge refresh_request_n) begin
    rf_t = $time;
  end

  always @(posedge refresh_request_n) begin
    if ($time - rf_t >= 5000) begin
      ext_count = ext_count + 1;
    end
  end
endmodule

//--- verif/tb.sv
/* Self-checking bench for psr_ctrl with the RAM model.
   Assumes 100 MHz ref_clk and the bound pin checker. */
`timescale 1ns/1ps
module tb;
  typedef struct packed { logic rd; psr_pkg::psr_data_t data; } psr_note_t;

  logic               ref_clk = 1'b0;
  logic               arst_n = 1'b0;
  logic               req_valid = 1'b0;
  psr_pkg::psr_op_t   req_op = psr_pkg::PSR_OP_READ;
  psr_pkg::psr_addr_t req_addr = 13'h0;
  psr_pkg::psr_data_t req_wdata = 8'h0;
  logic               req_ready, rsp_valid, ram_ce_n, ram_oe_n, ram_we_n;
  logic               refresh_request_n, ram_dq_oe;
  psr_pkg::psr_data_t rsp_rdata, ram_dq_in, ram_dq_out;
  psr_pkg::psr_addr_t ram_addr;
  int                 ext_count;
  int                 errors = 0;
  int                 total_checks = 0;
  int                 seed = 96;
  psr_note_t          exp_q [$];
  psr_note_t          note;
  psr_pkg::psr_data_t shadow [psr_pkg::psr_addr_t];
  psr_pkg::psr_addr_t adr [6];

  always #5 ref_clk = ~ref_clk;

  psr_ctrl u_psr_ctrl (.ref_clk(ref_clk), .arst_n(arst_n), .req_valid(req_valid),
    .req_op(req_op), .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .ram_ce_n(ram_ce_n), .ram_oe_n(ram_oe_n),
    .ram_we_n(ram_we_n), .refresh_request_n(refresh_request_n), .ram_addr(ram_addr),
    .ram_dq_in(ram_dq_in), .ram_dq_out(ram_dq_out), .ram_dq_oe(ram_dq_oe));

  psr_ram_model u_psr_ram_model (.ram_ce_n(ram_ce_n), .ram_oe_n(ram_oe_n),
    .ram_we_n(ram_we_n), .refresh_request_n(refresh_request_n), .ram_addr(ram_addr),
    .ram_dq_out(ram_dq_out), .ram_dq_oe(ram_dq_oe), .ram_dq_in(ram_dq_in),
    .ext_count(ext_count));

  // ----------------------------------------
  // Checking
  // ----------------------------------------
  task automatic compare_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic compare_byte(input psr_pkg::psr_data_t got, input psr_pkg::psr_data_t exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish;
    if (errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    if (arst_n === 1'b1 && rsp_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        compare_bit(rsp_valid, 1'b0);
      end else begin
        note = exp_q.pop_front();
        if (note.rd) begin
          compare_byte(rsp_rdata, note.data);
        end else begin
          compare_bit(refresh_request_n, 1'b1);
        end
      end
    end
  end

  // ----------------------------------------
  // Stimulus
  // ----------------------------------------
  // Valid stays up after a take so requests can run back to back
  task automatic do_req(input psr_pkg::psr_op_t op, input psr_pkg::psr_addr_t a,
                        input psr_pkg::psr_data_t d, input int hold);
    int n;
    req_valid <= 1'b1;
    req_op <= op;
    req_addr <= a;
    req_wdata <= d;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (req_ready !== 1'b1 && n < 12000);
    compare_bit(req_ready, 1'b1);
    if (op == psr_pkg::PSR_OP_WRITE) shadow[a] = d;
    if (op == psr_pkg::PSR_OP_READ) exp_q.push_back({1'b1, shadow[a]});
    if (op == psr_pkg::PSR_OP_EXT) exp_q.push_back({1'b0, 8'h0});
    repeat (hold) @(posedge ref_clk);
  endtask

  task automatic idle(input int n);
    req_valid <= 1'b0;
    repeat (n) @(posedge ref_clk);
  endtask

  initial begin
    repeat (3) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (100) @(posedge ref_clk);
    compare_bit(refresh_request_n, 1'b0);
    compare_bit(req_ready, 1'b0);
    for (int i = 0; i < 6; i++) begin
      adr[i] = (i < 2) ? {13{i[0]}} : 13'($random(seed));
      do_req(psr_pkg::PSR_OP_WRITE, adr[i], 8'($random(seed)), 0);
    end
    for (int i = 5; i >= 0; i--) begin
      do_req(psr_pkg::PSR_OP_READ, adr[i], 8'h0, 0);
    end
    do_req(psr_pkg::PSR_OP_DUMMY, adr[0], ~shadow[adr[0]], 0);
    do_req(psr_pkg::PSR_OP_READ, adr[0], 8'h0, 0);
    do_req(psr_pkg::PSR_OP_EXT, adr[1], 8'h0, 600);
    idle(40);
    compare_byte(8'(ext_count), 8'h02);
    do_req(psr_pkg::PSR_OP_DUMMY, adr[3], 8'h0, 0);
    idle(3300);
    do_req(psr_pkg::PSR_OP_READ, adr[1], 8'h0, 0);
    do_req(psr_pkg::PSR_OP_WRITE, adr[2], 8'($random(seed)), 0);
    idle(2);
    arst_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    compare_bit(ram_ce_n, 1'b1);
    compare_bit(refresh_request_n, 1'b0);
    compare_bit(ram_dq_oe, 1'b0);
    arst_n <= 1'b1;
    do_req(psr_pkg::PSR_OP_READ, adr[2], 8'h0, 0);
    idle(40);
    compare_byte(8'(exp_q.size()), 8'h00);
    tally_and_finish();
  end

  // Two init phases plus traffic stay well inside this span
  initial begin
    repeat (60000) @(posedge ref_clk);
    errors++;
    tally_and_finish();
  end
endmodule
